// >>> verification/nvmseq_cpu_model.sv
// CPU core model driving the register port of the sequencer
`timescale 1ns/1ps
module nvmseq_cpu_model (
    input wire logic ref_clk,
    output logic [7:0] sfr_addr,
    output logic sfr_wr,
    output logic sfr_rd,
    output logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata
);
    initial begin
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_wdata = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////
    // One-cycle write strobe; data inverted after release so stale
    // values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge ref_clk);
        sfr_wr <= 1'b0;
        sfr_wdata <= ~d;
    endtask

    // Read strobe, data taken once the registered answer has landed
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge ref_clk);
        sfr_rd <= 1'b0;
        @(posedge ref_clk);
        d = sfr_rdata;
    endtask
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the nonvolatile sequencer
`timescale 1ns/1ps
module tb_top;
    import nvmseq_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic osc_input = 1'b0;
    logic serial_irq_enable = 1'b0;
    logic idle_req = 1'b0;
    logic rst_pin = 1'b0;
    logic ext_code_pin = 1'b1;
    logic exec_external = 1'b0;
    logic code_table_read = 1'b0;
    logic [15:0] table_addr = 16'h0000;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rv;
    logic sfr_wr, sfr_rd, table_read_allow, nvm_irq_req;
    logic protect_active, op_in_progress, sys_reset;
    int failures = 0;
    int samples_checked = 0;

    always #2 ref_clk = ~ref_clk;
    // Fast oscillator keeps erase and write phases short
    always @(posedge ref_clk) osc_input <= ~osc_input;

    nvmseq_cpu_model nvmseq_cpu_model_i (.ref_clk(ref_clk),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));
    nvmseq_top nvmseq_top_i (.ref_clk(ref_clk), .reset(reset),
        .rst_pin(rst_pin), .osc_input(osc_input),
        .ext_code_pin(ext_code_pin),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .serial_irq_enable(serial_irq_enable), .idle_req(idle_req),
        .power_down_req(1'b0), .exec_external(exec_external),
        .code_table_read(code_table_read), .table_addr(table_addr),
        .table_read_allow(table_read_allow), .nvm_irq_req(nvm_irq_req),
        .protect_active(protect_active),
        .op_in_progress(op_in_progress), .sys_reset(sys_reset));

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
            input string what);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("Error %0t: %s got %h expected %h", $time, what,
                got, exp);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        nvmseq_cpu_model_i.rd(a, rv);
        chk(rv, exp, "register read");
    endtask

    // Bounded wait for the sequencer to finish
    task automatic wait_idle();
        int n;
        n = 0;
        while (op_in_progress !== 1'b0 && n < 12000) begin
            @(posedge ref_clk);
            n++;
        end
        chk({7'h00, op_in_progress}, 8'h00, "operation finish");
    endtask

    task automatic wrop(input logic [7:0] a, input logic [7:0] d);
        nvmseq_cpu_model_i.wr(a, d);
        @(posedge ref_clk);
        chk({7'h00, op_in_progress}, 8'h01, "operation start");
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic reset_values();
        rdchk(ADDR_HIGH_SFR, 8'h80);
        rdchk(ADDR_LOW_SFR, 8'h00);
        rdchk(TIMER_SFR, 8'h08);
        rdchk(CONTROL_SFR, 8'h00);
    endtask

    // Byte write to a cleared cell, with writes refused while busy
    task automatic byte_write();
        nvmseq_cpu_model_i.wr(TIMER_SFR, 8'h00);
        nvmseq_cpu_model_i.wr(ADDR_HIGH_SFR, 8'h00);
        nvmseq_cpu_model_i.wr(ADDR_LOW_SFR, 8'h05);
        nvmseq_cpu_model_i.wr(CONTROL_SFR, 8'h40);
        wrop(DATA_SFR, 8'hA5);
        nvmseq_cpu_model_i.wr(ADDR_LOW_SFR, 8'h33);
        nvmseq_cpu_model_i.wr(CONTROL_SFR, 8'h60);
        chk({7'h00, op_in_progress}, 8'h01, "busy held");
        wait_idle();
        rdchk(ADDR_LOW_SFR, 8'h05);
        rdchk(DATA_SFR, 8'hA5);
        rdchk(CONTROL_SFR, 8'hC0);
        serial_irq_enable <= 1'b1;
        @(posedge ref_clk);
        @(posedge ref_clk);
        chk({7'h00, nvm_irq_req}, 8'h01, "irq request");
        nvmseq_cpu_model_i.wr(CONTROL_SFR, 8'h00);
        @(posedge ref_clk);
        chk({7'h00, nvm_irq_req}, 8'h00, "irq cleared");
    endtask

    // Security byte vote, then block erase wipes everything
    task automatic security_cycle();
        nvmseq_cpu_model_i.wr(ADDR_HIGH_SFR, SEC_ADDR_HIGH);
        nvmseq_cpu_model_i.wr(ADDR_LOW_SFR, SEC_ADDR_LOW);
        wrop(DATA_SFR, 8'h0E);
        wait_idle();
        chk({7'h00, protect_active}, 8'h01, "protect set");
        // Protected and external: byte write must not start
        exec_external <= 1'b1;
        nvmseq_cpu_model_i.wr(DATA_SFR, 8'h5A);
        @(posedge ref_clk);
        chk({7'h00, op_in_progress}, 8'h00, "locked write");
        chk({7'h00, protect_active}, 8'h01, "protect kept");
        nvmseq_cpu_model_i.wr(CONTROL_SFR, {4'h0, OP_BLOCK_ERASE});
        wrop(DATA_SFR, 8'h77);
        wait_idle();
        exec_external <= 1'b0;
        chk({7'h00, protect_active}, 8'h00, "protect cleared");
        nvmseq_cpu_model_i.wr(CONTROL_SFR, 8'h00);
        nvmseq_cpu_model_i.wr(ADDR_HIGH_SFR, 8'h00);
        nvmseq_cpu_model_i.wr(ADDR_LOW_SFR, 8'h05);
        rdchk(DATA_SFR, 8'h00);
    endtask

    // Idle request in mid-write aborts without raising the flag
    task automatic abort_write();
        nvmseq_cpu_model_i.wr(ADDR_LOW_SFR, 8'h06);
        wrop(DATA_SFR, 8'h11);
        idle_req <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk({7'h00, op_in_progress}, 8'h00, "abort");
        idle_req <= 1'b0;
        rdchk(CONTROL_SFR, 8'h00);
    endtask

    task automatic table_reads();
        table_addr <= 16'h0100;
        code_table_read <= 1'b1;
        @(posedge ref_clk);
        code_table_read <= 1'b0;
        @(posedge ref_clk);
        chk({7'h00, table_read_allow}, 8'h01, "internal read");
        exec_external <= 1'b1;
        code_table_read <= 1'b1;
        @(posedge ref_clk);
        code_table_read <= 1'b0;
        @(posedge ref_clk);
        chk({7'h00, table_read_allow}, 8'h00, "external read");
        exec_external <= 1'b0;
    endtask

    // Pin reset qualified over 24 oscillator periods; strap taken then
    task automatic pin_reset();
        ext_code_pin <= 1'b0;
        rst_pin <= 1'b1;
        repeat (20) @(posedge ref_clk);
        chk({7'h00, sys_reset}, 8'h00, "early pin reset");
        repeat (60) @(posedge ref_clk);
        chk({7'h00, sys_reset}, 8'h01, "pin reset");
        rst_pin <= 1'b0;
        repeat (4) @(posedge ref_clk);
        ext_code_pin <= 1'b1;
        chk({7'h00, sys_reset}, 8'h00, "pin reset end");
        rdchk(TIMER_SFR, 8'h08);
        code_table_read <= 1'b1;
        @(posedge ref_clk);
        code_table_read <= 1'b0;
        @(posedge ref_clk);
        chk({7'h00, table_read_allow}, 8'h00, "strap read");
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        reset_values();
        byte_write();
        security_cycle();
        abort_write();
        table_reads();
        pin_reset();
        wrap_up();
    end

    // Watchdog well beyond the three timed operations
    initial begin
        #200000;
        failures++;
        wrap_up();
    end
endmodule

// >>> verilog/nvmseq_arr_if.sv
// Connection between the sequencer and its storage array
`timescale 1ns/1ps
interface nvmseq_arr_if;
    logic sec_sel;
    logic [7:0] addr;
    logic [7:0] rdata;
    logic wr;
    logic [7:0] wdata;
    logic row_clr;
    logic blk_clr;
    logic protect;
    modport ctrl (output sec_sel, addr, wr, wdata, row_clr, blk_clr,
        input rdata, protect);
    modport mem (input sec_sel, addr, wr, wdata, row_clr, blk_clr,
        output rdata, protect);
endinterface

// >>> verilog/nvmseq_array.sv
// Data byte array, security byte and derived protect bit
`timescale 1ns/1ps
module nvmseq_array
    import nvmseq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    nvmseq_arr_if.mem arr
);
    logic [7:0] mem_ff [256];
    logic [7:0] sec_ff;
    logic [2:0] sec_votes;

    // One flop byte per entry; erase and write applied per byte
    for (genvar i = 0; i < 256; i++) begin : g_byte
        always_ff @(posedge ref_clk) begin
            if (reset) begin
                mem_ff[i] <= CELL_CLEAR;
            end else if (arr.blk_clr) begin
                mem_ff[i] <= CELL_CLEAR;
            end else if (arr.row_clr && !arr.sec_sel &&
                         arr.addr[7:3] == 5'(i / 8)) begin
                mem_ff[i] <= CELL_CLEAR;
            end else if (arr.wr && !arr.sec_sel && arr.addr == 8'(i)) begin
                mem_ff[i] <= arr.wdata;
            end
        end
    end

    // Security byte: block erase clears it, byte write sets it
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sec_ff <= CELL_CLEAR;
        end else if (arr.blk_clr) begin
            sec_ff <= CELL_CLEAR;
        end else if (arr.wr && arr.sec_sel) begin
            sec_ff <= arr.wdata;
        end
    end

    // Read port
    assign arr.rdata = arr.sec_sel ? sec_ff : mem_ff[arr.addr];
    // Vote of the four security bits
    assign sec_votes = 3'(sec_ff[0]) + 3'(sec_ff[1]) + 3'(sec_ff[2])
        + 3'(sec_ff[3]);
    assign arr.protect = sec_votes >= 3'(SEC_VOTE_MIN);

    a_protect_vote: assert property (@(posedge ref_clk) disable iff (reset)
        (sec_ff[3:0] == 4'hF) |-> arr.protect)
        else $error("protect bit low with all security bits set");
endmodule

// >>> verilog/nvmseq_pkg.sv
// Constants shared by the nonvolatile sequencer and its helpers
package nvmseq_pkg;
    // Register addresses on the CPU register port
    localparam logic [7:0] ADDR_LOW_SFR = 8'hF2;
    localparam logic [7:0] ADDR_HIGH_SFR = 8'hF3;
    localparam logic [7:0] DATA_SFR = 8'hF4;
    localparam logic [7:0] TIMER_SFR = 8'hF5;
    localparam logic [7:0] CONTROL_SFR = 8'hF6;
    // Reset values
    localparam logic [7:0] ADDR_HIGH_RST = 8'h80;
    localparam logic [7:0] ADDR_LOW_RST = 8'h00;
    localparam logic [7:0] TIMER_RST = 8'h08;
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    // Control register field positions
    localparam int IRQ_FLAG_BIT = 7;
    localparam int IRQ_EN_BIT = 6;
    localparam int BUSY_BIT = 5;
    // Operation codes in the low control nibble
    localparam logic [3:0] OP_BYTE = 4'h0;
    localparam logic [3:0] OP_ROW_ERASE = 4'hC;
    localparam logic [3:0] OP_BLOCK_ERASE = 4'hA;
    // Security byte location and cleared cell value
    localparam logic [7:0] SEC_ADDR_HIGH = 8'h80;
    localparam logic [7:0] SEC_ADDR_LOW = 8'h00;
    localparam logic [7:0] CELL_CLEAR = 8'h00;
    localparam int SEC_VOTE_MIN = 3;
    // Program memory boundary for table reads
    localparam logic [15:0] INT_ROM_LIMIT = 16'h1000;
    // Reset pin qualification, in oscillator periods
    localparam int RST_OSC_PERIODS = 24;
    localparam logic [4:0] RST_QUAL_CNT = 5'(RST_OSC_PERIODS);
    // Timer scaling: one timer unit is 1024 oscillator periods,
    // counted on the half-rate tick; the register adds a bias of 2
    localparam int OSC_PER_UNIT = 1024;
    localparam logic [9:0] UNIT_TICKS = 10'(OSC_PER_UNIT / 2);
    localparam logic [8:0] TIMER_BIAS = 9'h002;
    // Mask-programmed ROM protection bit; value set at mask time
    localparam logic ROM_PROTECT = 1'b1;
endpackage

// >>> verilog/nvmseq_reset_qual.sv
// Oscillator pin divider and reset pin qualification
`timescale 1ns/1ps
module nvmseq_reset_qual
    import nvmseq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic rst_pin,
    input wire logic osc_input,
    output logic osc_tick,
    output logic qual_reset
);
    logic [1:0] osc_sync_ff;
    logic [1:0] rst_sync_ff;
    logic osc_last_ff;
    logic half_ff;
    logic osc_rise;
    logic [4:0] rst_cnt_ff;
    logic qual_ff;

    // Pins are asynchronous; two flops before any use
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            osc_sync_ff <= 2'h0;
            rst_sync_ff <= 2'h0;
            osc_last_ff <= 1'b0;
        end else begin
            osc_sync_ff <= {osc_sync_ff[0], osc_input};
            rst_sync_ff <= {rst_sync_ff[0], rst_pin};
            osc_last_ff <= osc_sync_ff[1];
        end
    end
    assign osc_rise = osc_sync_ff[1] && !osc_last_ff;

    // divide by two; only rising edges count, so duty is irrelevant
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            half_ff <= 1'b0;
        end else if (osc_rise) begin
            half_ff <= !half_ff;
        end
    end
    assign osc_tick = osc_rise && half_ff;

    // pin must stay high for 24 oscillator periods
    always_ff @(posedge ref_clk) begin
        if (reset || !rst_sync_ff[1]) begin
            rst_cnt_ff <= 5'h00;
            qual_ff <= 1'b0;
        end else if (osc_rise && rst_cnt_ff != RST_QUAL_CNT) begin
            rst_cnt_ff <= rst_cnt_ff + 5'h01;
        end else if (rst_cnt_ff == RST_QUAL_CNT) begin
            qual_ff <= 1'b1;
        end
    end
    assign qual_reset = qual_ff;

    a_rst_qualified: assert property (@(posedge ref_clk) disable iff (reset)
        $rose(qual_ff) |-> $past(rst_cnt_ff) == RST_QUAL_CNT)
        else $error("reset taken before qualification");
endmodule

// >>> verilog/nvmseq_top.sv
// Nonvolatile memory sequencer with security and code protection
`timescale 1ns/1ps

// Functional notes
// - Interrupt flag: sequencer or software sets, software clears
// - Enable bit gates flag onto interrupt request
// - Busy flag owned by sequencer, writes ignored
// - Array access refused while busy
// - Codes: 0 byte, 0CH row, 0AH block
// - Byte read default; data shows addressed byte
// - Data register write starts every operation
// - Byte write erases first unless cell is 00H
// - Row erase clears 8 bytes, ignores low bits
// - Block erase clears all bytes and security byte
// - Reset values: 80H, 00H, 08H, 00H
// - Security byte at 8000H, written in byte mode
// - Protect set when three or four bits set
// - Protected external mode allows only block erase
// - Block erase completion clears protect and busy
// - Security write blocked when protected and external
// - Lower 4K table reads only from internal code
// - External mode strapped only during reset
// - ROM protection blocks external reads of internal
// - Reset pin qualified over 24 oscillator periods
// - Oscillator input divided by two
// - Idle or power-down aborts running operation
// - Timer register scales operation duration
// - Low address picks byte; high reaches security
// - Interrupt also needs serial interrupt enabled
module nvmseq_top
    import nvmseq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic rst_pin,
    input wire logic osc_input,
    input wire logic ext_code_pin,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic serial_irq_enable,
    input wire logic idle_req,
    input wire logic power_down_req,
    input wire logic exec_external,
    input wire logic code_table_read,
    input wire logic [15:0] table_addr,
    output logic table_read_allow,
    output logic nvm_irq_req,
    output logic protect_active,
    output logic op_in_progress,
    output logic sys_reset
);
    typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_WRITE} nvmseq_st_type;

    nvmseq_st_type state_ff;
    nvmseq_st_type nxt_state;
    logic [7:0] addr_high_ff;
    logic [7:0] addr_low_ff;
    logic [7:0] timer_ff;
    logic [7:0] data_ff;
    logic [3:0] op_code_ff;
    logic [3:0] run_op_ff;
    logic irq_flag_ff;
    logic irq_en_ff;
    logic ext_mode_ff;
    logic [7:0] rdata_ff;
    logic allow_ff;
    logic [9:0] tick_cnt_ff;
    logic [8:0] unit_cnt_ff;
    logic osc_tick;
    logic qual_reset;
    logic srst;
    logic busy;
    logic ext_eff;
    logic locked;
    logic wr_addr_high;
    logic wr_addr_low;
    logic wr_timer;
    logic wr_control;
    logic wr_data;
    logic start;
    logic start_ok;
    logic phase_done;
    logic op_done;
    logic abort;
    logic [7:0] ctrl_view;

    nvmseq_arr_if arr ();

    ////////////////////////////////////////////////////////////////////
    // Helpers: reset qualification and array

    nvmseq_reset_qual u_rstq (
        .ref_clk(ref_clk),
        .reset(reset),
        .rst_pin(rst_pin),
        .osc_input(osc_input),
        .osc_tick(osc_tick),
        .qual_reset(qual_reset)
    );

    // Qualified pin reset acts like the bench reset here; the array takes only the bench reset
    assign srst = reset || qual_reset;
    assign sys_reset = srst;

    nvmseq_array u_arr (
        .ref_clk(ref_clk),
        .reset(reset),
        .arr(arr)
    );

    ////////////////////////////////////////////////////////////////////
    // Decode and access qualification

    assign busy = state_ff != ST_IDLE;
    // External mode counts whether strapped or past the 4K boundary
    assign ext_eff = ext_mode_ff || exec_external;
    // protected external mode locks all but block erase
    assign locked = arr.protect && ext_eff;
    // writes to address, timer and data dropped while busy; control write always decoded
    assign wr_addr_high = sfr_wr && sfr_addr == ADDR_HIGH_SFR && !busy;
    assign wr_addr_low = sfr_wr && sfr_addr == ADDR_LOW_SFR && !busy;
    assign wr_timer = sfr_wr && sfr_addr == TIMER_SFR && !busy;
    assign wr_control = sfr_wr && sfr_addr == CONTROL_SFR;
    assign wr_data = sfr_wr && sfr_addr == DATA_SFR && !busy;
    // data write is the start strobe
    assign start = wr_data;
    // only known codes run; locked allows block erase only
    assign start_ok = start && ((op_code_ff == OP_BLOCK_ERASE) ||
        (!locked && (op_code_ff == OP_BYTE ||
        op_code_ff == OP_ROW_ERASE)));
    // low-power entry aborts the running operation
    assign abort = busy && (idle_req || power_down_req);

    // security byte only at 8000H, else low address
    assign arr.sec_sel = addr_high_ff == SEC_ADDR_HIGH &&
        addr_low_ff == SEC_ADDR_LOW;
    assign arr.addr = addr_low_ff;

    ////////////////////////////////////////////////////////////////////
    // Address, timer and data registers

    // address reset points at the security byte
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            addr_high_ff <= ADDR_HIGH_RST;
            addr_low_ff <= ADDR_LOW_RST;
        end else begin
            if (wr_addr_high) begin
                addr_high_ff <= sfr_wdata;
            end
            if (wr_addr_low) begin
                addr_low_ff <= sfr_wdata;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            timer_ff <= TIMER_RST;
        end else if (wr_timer) begin
            timer_ff <= sfr_wdata;
        end
    end

    // Data register keeps the byte to be written
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            data_ff <= DATA_RST;
        end else if (wr_data) begin
            data_ff <= sfr_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control register

    // operation code; reserved bit 4 not stored
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            op_code_ff <= CONTROL_RST[3:0];
            irq_en_ff <= CONTROL_RST[IRQ_EN_BIT];
        end else if (wr_control && !busy) begin
            op_code_ff <= sfr_wdata[3:0];
            irq_en_ff <= sfr_wdata[IRQ_EN_BIT];
        end
    end

    // completion sets the flag and wins over a software clear
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq_flag_ff <= CONTROL_RST[IRQ_FLAG_BIT];
        end else if (op_done) begin
            irq_flag_ff <= 1'b1;
        end else if (wr_control) begin
            irq_flag_ff <= sfr_wdata[IRQ_FLAG_BIT];
        end
    end

    // strap caught only while reset is held
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ext_mode_ff <= !ext_code_pin;
        end
    end

    // busy bit reflects the sequencer, never the write data
    assign ctrl_view = {irq_flag_ff, irq_en_ff, busy, 1'b0, op_code_ff};

    ////////////////////////////////////////////////////////////////////
    // Register read path

    // data reads show the array only when idle and unlocked
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rdata_ff <= 8'h00;
        end else if (sfr_rd) begin
            unique case (sfr_addr)
                ADDR_HIGH_SFR: rdata_ff <= addr_high_ff;
                ADDR_LOW_SFR: rdata_ff <= addr_low_ff;
                TIMER_SFR: rdata_ff <= timer_ff;
                CONTROL_SFR: rdata_ff <= ctrl_view;
                DATA_SFR: rdata_ff <= (busy || locked) ? data_ff :
                    arr.rdata;
                default: rdata_ff <= 8'h00;
            endcase
        end
    end
    assign sfr_rdata = rdata_ff;

    ////////////////////////////////////////////////////////////////////
    // Sequencer timing

    // duration is (timer + 2) units of half-rate ticks
    always_ff @(posedge ref_clk) begin
        if (srst || !busy || phase_done) begin
            tick_cnt_ff <= 10'h000;
            unit_cnt_ff <= 9'h000;
        end else if (osc_tick) begin
            if (tick_cnt_ff == UNIT_TICKS - 10'h001) begin
                tick_cnt_ff <= 10'h000;
                unit_cnt_ff <= unit_cnt_ff + 9'h001;
            end else begin
                tick_cnt_ff <= tick_cnt_ff + 10'h001;
            end
        end
    end
    assign phase_done = busy &&
        unit_cnt_ff == {1'b0, timer_ff} + TIMER_BIAS;

    ////////////////////////////////////////////////////////////////////
    // Sequencer state machine

    // old contents pick erase-then-write or write only
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (start_ok) begin
                    if (op_code_ff == OP_BYTE && arr.rdata == CELL_CLEAR) begin
                        nxt_state = ST_WRITE;
                    end else begin
                        nxt_state = ST_ERASE;
                    end
                end
            end
            ST_ERASE: begin
                if (abort) begin
                    nxt_state = ST_IDLE;
                end else if (phase_done) begin
                    nxt_state = (run_op_ff == OP_BYTE) ? ST_WRITE : ST_IDLE;
                end
            end
            ST_WRITE: begin
                if (abort || phase_done) begin
                    nxt_state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Operation latched at start so a later code change cannot leak in
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            run_op_ff <= OP_BYTE;
        end else if (start_ok) begin
            run_op_ff <= op_code_ff;
        end
    end

    assign op_done = busy && phase_done && !abort &&
        (state_ff == ST_WRITE || run_op_ff != OP_BYTE);

    // erase effects land at the end of the erase time
    assign arr.row_clr = state_ff == ST_ERASE && phase_done && !abort &&
        run_op_ff == OP_ROW_ERASE;
    assign arr.blk_clr = state_ff == ST_ERASE && phase_done && !abort &&
        run_op_ff == OP_BLOCK_ERASE;
    // Byte erase writes the cleared value, then the new data
    assign arr.wr = phase_done && !abort && run_op_ff == OP_BYTE;
    assign arr.wdata = (state_ff == ST_ERASE) ? CELL_CLEAR : data_ff;

    ////////////////////////////////////////////////////////////////////
    // Table reads and outputs

    // lower 4K reachable only from internal code
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            allow_ff <= 1'b0;
        end else if (code_table_read) begin
            allow_ff <= table_addr >= INT_ROM_LIMIT ||
                (!ext_eff && !(ROM_PROTECT && exec_external));
        end else begin
            allow_ff <= 1'b0;
        end
    end
    assign table_read_allow = allow_ff;

    // enable and serial enable gate the request
    assign nvm_irq_req = irq_flag_ff && irq_en_ff && serial_irq_enable;
    assign protect_active = arr.protect;
    assign op_in_progress = busy;

    ////////////////////////////////////////////////////////////////////
    // Checks

    a_done_sets_flag: assert property (@(posedge ref_clk) disable iff (srst)
        op_done |=> irq_flag_ff)
        else $error("completion did not set flag");
    a_irq_gating: assert property (@(posedge ref_clk) disable iff (srst)
        nvm_irq_req |-> irq_flag_ff && irq_en_ff && serial_irq_enable)
        else $error("interrupt raised without enables");
    a_busy_sw_proof: assert property (@(posedge ref_clk) disable iff (srst)
        (!busy && wr_control && !start_ok) |=> !op_in_progress)
        else $error("software write set busy flag");
    a_busy_refuse: assert property (@(posedge ref_clk) disable iff (srst)
        (busy && sfr_wr && sfr_addr == ADDR_LOW_SFR)
        |=> $stable(addr_low_ff))
        else $error("address changed during operation");
    a_locked_refuse: assert property (@(posedge ref_clk) disable iff (srst)
        (start && locked && op_code_ff != OP_BLOCK_ERASE)
        |=> !op_in_progress)
        else $error("locked device started an operation");
    a_blk_clears: assert property (@(posedge ref_clk) disable iff (srst)
        arr.blk_clr |=> !protect_active && !op_in_progress)
        else $error("block erase left protect or busy set");
    a_write_only: assert property (@(posedge ref_clk) disable iff (srst)
        (start_ok && op_code_ff == OP_BYTE && arr.rdata == CELL_CLEAR)
        |=> state_ff == ST_WRITE)
        else $error("cleared cell was erased again");
    a_abort_stops: assert property (@(posedge ref_clk) disable iff (srst)
        abort |=> !op_in_progress ##1 !irq_flag_ff || $past(irq_flag_ff))
        else $error("low power did not abort operation");
    a_reset_vals: assert property (@(posedge ref_clk)
        $fell(srst) |-> addr_high_ff == ADDR_HIGH_RST &&
        timer_ff == TIMER_RST && op_code_ff == OP_BYTE)
        else $error("wrong register values after reset");
endmodule
